// file: common/irq_pkg.sv
/*
 * constants, register map and carrier types of the interrupt controller.
 * assumes a 4-bit data bus, 8-bit i/o addresses and a 12-bit program counter.
 */
package irq_pkg;

  // ****************************************************************
  // register offsets
  // ****************************************************************
  localparam logic [7:0] ADDR_KEY_MASKS = 8'he8;
  localparam logic [7:0] ADDR_PORT_SERIAL_MASKS = 8'he9;
  localparam logic [7:0] ADDR_LAP_MASKS = 8'hea;
  localparam logic [7:0] ADDR_TICK_MASKS = 8'heb;
  localparam logic [7:0] ADDR_SERIAL_FLAG = 8'hec;
  localparam logic [7:0] ADDR_PORT_FLAGS = 8'hed;
  localparam logic [7:0] ADDR_LAP_FLAGS = 8'hee;
  localparam logic [7:0] ADDR_TICK_FLAGS = 8'hef;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int BIT_TICK_SLOW = 2;
  localparam int BIT_TICK_MID = 1;
  localparam int BIT_TICK_FAST = 0;
  localparam int BIT_LAP_SLOW = 1;
  localparam int BIT_LAP_FAST = 0;
  localparam int BIT_AUX_FLAG = 1;
  localparam int BIT_KEY_FLAG = 0;
  localparam int BIT_SERIAL_FLAG = 0;
  localparam int BIT_AUX_MASK = 2;
  localparam int BIT_SERIAL_MASK = 0;

  // ****************************************************************
  // reset values and vectors
  // ****************************************************************
  localparam logic [3:0] DATA_ZERO = 4'h0;
  localparam logic [3:0] VECTOR_PAGE = 4'h1;
  localparam logic [7:0] STEP_RESET = 8'h00;
  localparam logic [7:0] STEP_SERIAL = 8'h08;
  localparam logic [7:0] STEP_NONE = 8'h00;
  localparam int ENTRY_CYCLES = 12;

  // ****************************************************************
  // carriers
  // ****************************************************************
  typedef struct packed {
    logic [7:0] addr;
    logic [3:0] wdata;
    logic write;
    logic read;
  } reg_req_t;

  typedef struct packed {
    logic tick_slow;
    logic tick_mid;
    logic tick_fast;
    logic lap_slow;
    logic lap_fast;
    logic [3:0] key_lines;
    logic aux_port;
    logic serial_done;
  } irq_events_t;

  typedef struct packed {
    logic boundary;
    logic halt_exec;
    logic sleep_exec;
    logic global_irq_on;
    logic global_irq_off;
  } cpu_ctl_t;

  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_HALT = 2'b01,
    ST_SLEEP = 2'b10,
    ST_ENTRY = 2'b11
  } cpu_state_t;

endpackage

// file: dv/cpu_model.sv
/*
 * behavioural cpu core beside the controller: steps the program counter.
 * assumes the bench pulses halt, sleep and enable commands one cycle.
 */
module cpu_model
  import irq_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic hold_in,
  input wire logic [2:0] cmd_in,
  output cpu_ctl_t ctl_out,
  output logic [11:0] pc_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // the core stalls while held, so the pc freezes one step past the return address
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pc_out <= 12'h000;
    end else if (!hold_in) begin
      pc_out <= pc_out + 12'h001;
    end
  end
  assign ctl_out = {!hold_in, cmd_in, 1'b0};
endmodule // cpu_model

// file: dv/irq_controller_props.sv
/*
 * concurrent checks on the interrupt controller top ports.
 * assumes one clock domain and the asynchronous active low reset.
 */
module irq_controller_props #(
  parameter int PC_WIDTH = 12
) (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input irq_pkg::reg_req_t reg_req_in,
  input wire logic [3:0] rdata_out,
  input wire logic irq_req_out,
  input wire logic cpu_hold_out,
  input wire logic stack_push_out,
  input wire logic vector_load_out,
  input wire logic [PC_WIDTH-1:0] vector_out,
  input wire logic global_irq_flag_out,
  input wire logic osc_run_out,
  input wire logic lcd_power_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  // ****************************************************************
  // assertions
  // ****************************************************************
  chk_req_gate: assert property (irq_req_out |-> global_irq_flag_out)
    else $error("request while global enable is off");
  chk_accept_clear: assert property (stack_push_out |-> !global_irq_flag_out)
    else $error("global enable still set on entry");
  chk_entry_len: assert property (stack_push_out |-> ##11 vector_load_out)
    else $error("vector load not eleven cycles after push");
  chk_entry_hold: assert property (stack_push_out |-> cpu_hold_out[*8])
    else $error("hold dropped during entry");
  chk_hold_end: assert property (vector_load_out |=> !cpu_hold_out)
    else $error("hold stays after vector load");
  chk_vec_range: assert property (stack_push_out |->
    vector_out[11:8] == 4'h1 && vector_out[7:0] inside {[8'h01:8'h08]})
    else $error("vector outside page one range");
  chk_rdata_idle: assert property (!$past(reg_req_in.read) |-> rdata_out == 4'h0)
    else $error("read data outside read answer cycle");
  chk_sleep_osc: assert property (!osc_run_out |-> cpu_hold_out && !lcd_power_out)
    else $error("oscillator stopped outside sleep");
  chk_wake_path: assert property ($fell(cpu_hold_out) |-> $past(vector_load_out))
    else $error("cpu released without entry sequence");
endmodule // irq_controller_props

bind irq_controller irq_controller_props #(.PC_WIDTH(PC_WIDTH)) u_props (
  .clk_in(clk_in), .reset_n_in(reset_n_in), .reg_req_in(reg_req_in),
  .rdata_out(rdata_out), .irq_req_out(irq_req_out),
  .cpu_hold_out(cpu_hold_out), .stack_push_out(stack_push_out),
  .vector_load_out(vector_load_out), .vector_out(vector_out),
  .global_irq_flag_out(global_irq_flag_out), .osc_run_out(osc_run_out),
  .lcd_power_out(lcd_power_out));

// file: dv/tb_top.sv
/*
 * self-checking bench for the interrupt controller.
 * assumes the cpu model drives the core strobes and next program step.
 */
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import irq_pkg::*;
  logic clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  reg_req_t req = '0;
  irq_events_t ev = '0;
  logic [2:0] cmd = 3'h0;
  cpu_ctl_t ctl;
  logic [11:0] pc, push_addr, vec;
  logic [3:0] rdata;
  logic req_o, hold, push, load, ge, osc, lcd;
  int failures = 0;
  int checks_done = 0;
  irq_events_t fev [8] = '{11'h400, 11'h200, 11'h100, 11'h080, 11'h040,
    11'h020, 11'h002, 11'h001};
  logic [7:0] fad [8] = '{8'hef, 8'hef, 8'hef, 8'hee, 8'hee, 8'hed, 8'hed,
    8'hec};
  logic [3:0] fex [8] = '{4'h4, 4'h2, 4'h1, 4'h2, 4'h1, 4'h1, 4'h2, 4'h1};
  logic [3:0] mex [4] = '{4'hf, 4'h5, 4'h3, 4'h7};
  always #50 clk_in = ~clk_in;
  irq_controller dut (.clk_in(clk_in), .reset_n_in(reset_n_in),
    .reg_req_in(req), .rdata_out(rdata), .events_in(ev), .cpu_ctl_in(ctl),
    .next_pc_in(pc), .irq_req_out(req_o), .cpu_hold_out(hold),
    .stack_push_out(push), .push_addr_out(push_addr),
    .vector_load_out(load), .vector_out(vec), .global_irq_flag_out(ge),
    .osc_run_out(osc), .lcd_power_out(lcd));
  cpu_model core (.clk_in(clk_in), .reset_n_in(reset_n_in), .hold_in(hold),
    .cmd_in(cmd), .ctl_out(ctl), .pc_out(pc));
  // ****************************************************************
  // access tasks
  // ****************************************************************
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    checks_done++;
    if (got !== exp) begin
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      failures++;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [3:0] d);
    @(posedge clk_in);
    req <= {a, d, 2'b10};
    @(posedge clk_in);
    req <= '0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [3:0] e);
    @(posedge clk_in);
    req <= {a, 4'h0, 2'b01};
    @(posedge clk_in);
    req <= '0;
    #1 chk({8'h00, rdata}, {8'h00, e});
  endtask
  task automatic pulse(input irq_events_t e);
    @(posedge clk_in);
    ev <= e;
    @(posedge clk_in);
    ev <= '0;
  endtask
  task automatic cpu(input logic [2:0] c);
    @(posedge clk_in);
    cmd <= c;
    @(posedge clk_in);
    cmd <= 3'h0;
  endtask
  task automatic entry(input logic [11:0] v);
    int n;
    n = 0;
    #1;
    while (push !== 1'b1 && n < 40) begin
      @(posedge clk_in);
      #1 n++;
    end
    chk(vec, v);
    chk(push_addr, pc - 12'h001);
    chk({11'h000, ge}, 12'h000);
    n = 0;
    while (load !== 1'b1 && n < 40) begin
      @(posedge clk_in);
      #1 n++;
    end
    chk(n[11:0], 12'h00b);
    @(posedge clk_in);
    #1 chk({11'h000, hold}, 12'h000);
  endtask
  task automatic results();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // ****************************************************************
  // tests
  // ****************************************************************
  initial begin
    #200000;
    failures++;
    results();
  end
  initial begin
    repeat (12) @(posedge clk_in);
    reset_n_in <= 1'b1;
    wr(8'hef, 4'hf);
    for (int i = 0; i < 8; i++) rd(8'he8 + i, 4'h0);
    rd(8'hf0, 4'h0);
    $display("reset test done");
    for (int i = 0; i < 4; i++) begin
      wr(8'he8 + i, 4'hf);
      rd(8'he8 + i, mex[i]);
      wr(8'he8 + i, 4'h0);
    end
    // flags read only while enable is off
    for (int i = 0; i < 8; i++) begin
      pulse(fev[i]);
      rd(fad[i], fex[i]);
      rd(fad[i], 4'h0);
    end
    $display("map test done");
    cpu(3'b001);
    pulse(11'h100);
    #1 chk({11'h000, req_o}, 12'h000);
    rd(8'hef, 4'h1);
    wr(8'heb, 4'h1);
    wr(8'hea, 4'h1);
    pulse(11'h140);
    entry(12'h103);
    rd(8'hef, 4'h1);
    rd(8'hee, 4'h1);
    wr(8'he9, 4'h1);
    pulse(11'h001);
    #1 chk({11'h000, req_o}, 12'h000);
    cpu(3'b001);
    entry(12'h108);
    pulse(11'h100);
    cpu(3'b001);
    entry(12'h101);
    rd(8'hef, 4'h1);
    rd(8'hec, 4'h1);
    $display("entry test done");
    wr(8'he8, 4'h4);
    cpu(3'b001);
    cpu(3'b100);
    repeat (3) @(posedge clk_in);
    #1 chk({10'h000, hold, osc}, 12'h003);
    pulse(11'h010);
    entry(12'h104);
    rd(8'hed, 4'h1);
    $display("halt test done");
    cpu(3'b001);
    cpu(3'b010);
    pulse(11'h100);
    repeat (2) @(posedge clk_in);
    #1 chk({10'h000, hold, osc}, 12'h002);
    chk({11'h000, lcd}, 12'h000);
    pulse(11'h008);
    entry(12'h105);
    chk({11'h000, osc}, 12'h001);
    rd(8'hef, 4'h1);
    rd(8'hed, 4'h1);
    $display("sleep test done");
    results();
  end
endmodule // tb_top

// file: hw/irq_controller.sv
/*
 * maskable interrupt controller with halt and sleep wake-up for a 4-bit
 * cpu core. assumes the core pulses the cpu control strobes, offers
 * next_pc at each instruction boundary and stalls while hold is high.
 */
// The strobed register port was decided locally.
// Behaviour
// - request needs flag, mask and global enable
// - acceptance clears the global enable
// - flags read-only, cleared by read, reset zero
// - masks read-write, never block flag setting
// - all masks reset to zero
// - four key masks share one key flag
// - tick flags and masks at their addresses
// - lap flags and masks at their addresses
// - aux and serial flags and masks placed
// - aux source exists only when input-only
// - push return address, load page-1 vector
// - entry sequence takes exactly twelve cycles
// - vector steps per source group
// - halt stops cpu, any interrupt wakes
// - sleep stops clocks, only input wakes
// - halt return lands after halt instruction
module irq_controller #(
  parameter int PC_WIDTH = 12,
  parameter bit AUX_INPUT_ONLY = 1'b1,
  parameter bit SLEEP_OPTION = 1'b1
) (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input irq_pkg::reg_req_t reg_req_in,
  output logic [3:0] rdata_out,
  input irq_pkg::irq_events_t events_in,
  input irq_pkg::cpu_ctl_t cpu_ctl_in,
  input wire logic [PC_WIDTH-1:0] next_pc_in,
  output logic irq_req_out,
  output logic cpu_hold_out,
  output logic stack_push_out,
  output logic [PC_WIDTH-1:0] push_addr_out,
  output logic vector_load_out,
  output logic [PC_WIDTH-1:0] vector_out,
  output logic global_irq_flag_out,
  output logic osc_run_out,
  output logic lcd_power_out
);
  import irq_pkg::*;

  localparam logic [3:0] ENTRY_LAST = 4'(ENTRY_CYCLES - 1);
  localparam logic [3:0] CNT_ONE = 4'h1;
  localparam logic [3:0] CNT_ZERO = 4'h0;

  // ****************************************************************
  // state
  // ****************************************************************
  logic [2:0] tick_flags;
  logic [1:0] lap_flags;
  logic key_port_flag;
  logic aux_port_flag;
  logic serial_done_flag;
  logic [2:0] tick_masks;
  logic [1:0] lap_masks;
  logic [3:0] key_masks;
  logic aux_port_mask;
  logic serial_done_mask;
  logic global_irq_on;
  cpu_state_t state;
  logic [3:0] entry_cnt;
  logic [PC_WIDTH-1:0] ret_addr;

  logic tick_pend;
  logic lap_pend;
  logic input_pend;
  logic serial_pend;
  logic any_pend;
  logic accept;
  logic [7:0] step;
  logic aux_event;
  logic rd_tick;
  logic rd_lap;
  logic rd_port;
  logic rd_serial;
  logic sleep_go;

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic is_read(input reg_req_t req,
                                   input logic [7:0] where);
    is_read = req.read && (req.addr == where);
  endfunction

  function automatic logic is_write(input reg_req_t req,
                                    input logic [7:0] where);
    is_write = req.write && (req.addr == where);
  endfunction

  function automatic logic next_flag(input logic cur, input logic ev,
                                     input logic rd);
    next_flag = ev | (cur & ~rd);
  endfunction

  function automatic logic entry_at(input cpu_state_t st,
                                    input logic [3:0] cnt,
                                    input logic [3:0] at);
    entry_at = (st == ST_ENTRY) && (cnt == at);
  endfunction

  assign rd_tick = is_read(reg_req_in, ADDR_TICK_FLAGS);
  assign rd_lap = is_read(reg_req_in, ADDR_LAP_FLAGS);
  assign rd_port = is_read(reg_req_in, ADDR_PORT_FLAGS);
  assign rd_serial = is_read(reg_req_in, ADDR_SERIAL_FLAG);
  assign aux_event = AUX_INPUT_ONLY && events_in.aux_port;
  assign sleep_go = cpu_ctl_in.sleep_exec && SLEEP_OPTION;

  // ****************************************************************
  // factor flags
  // ****************************************************************
  // an event in the read cycle survives the clear
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      tick_flags <= 3'h0;
    end else begin
      tick_flags[BIT_TICK_SLOW] <= next_flag(tick_flags[BIT_TICK_SLOW],
        events_in.tick_slow, rd_tick);
      tick_flags[BIT_TICK_MID] <= next_flag(tick_flags[BIT_TICK_MID],
        events_in.tick_mid, rd_tick);
      tick_flags[BIT_TICK_FAST] <= next_flag(tick_flags[BIT_TICK_FAST],
        events_in.tick_fast, rd_tick);
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      lap_flags <= 2'h0;
    end else begin
      lap_flags[BIT_LAP_SLOW] <= next_flag(lap_flags[BIT_LAP_SLOW],
        events_in.lap_slow, rd_lap);
      lap_flags[BIT_LAP_FAST] <= next_flag(lap_flags[BIT_LAP_FAST],
        events_in.lap_fast, rd_lap);
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      key_port_flag <= 1'b0;
      aux_port_flag <= 1'b0;
    end else begin
      key_port_flag <= next_flag(key_port_flag,
        |events_in.key_lines, rd_port);
      aux_port_flag <= next_flag(aux_port_flag, aux_event, rd_port);
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      serial_done_flag <= 1'b0;
    end else begin
      serial_done_flag <= next_flag(serial_done_flag,
        events_in.serial_done, rd_serial);
    end
  end

  // ****************************************************************
  // mask registers
  // ****************************************************************
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      key_masks <= 4'h0;
    end else if (is_write(reg_req_in, ADDR_KEY_MASKS)) begin
      key_masks <= reg_req_in.wdata;
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      aux_port_mask <= 1'b0;
      serial_done_mask <= 1'b0;
    end else if (is_write(reg_req_in, ADDR_PORT_SERIAL_MASKS)) begin
      aux_port_mask <= reg_req_in.wdata[BIT_AUX_MASK];
      serial_done_mask <= reg_req_in.wdata[BIT_SERIAL_MASK];
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      lap_masks <= 2'h0;
    end else if (is_write(reg_req_in, ADDR_LAP_MASKS)) begin
      lap_masks <= reg_req_in.wdata[1:0];
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      tick_masks <= 3'h0;
    end else if (is_write(reg_req_in, ADDR_TICK_MASKS)) begin
      tick_masks <= reg_req_in.wdata[2:0];
    end
  end

  // ****************************************************************
  // read port
  // ****************************************************************
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rdata_out <= DATA_ZERO;
    end else if (reg_req_in.read) begin
      case (reg_req_in.addr)
        ADDR_KEY_MASKS: rdata_out <= key_masks;
        ADDR_PORT_SERIAL_MASKS: begin
          rdata_out <= DATA_ZERO;
          rdata_out[BIT_AUX_MASK] <= aux_port_mask;
          rdata_out[BIT_SERIAL_MASK] <= serial_done_mask;
        end
        ADDR_LAP_MASKS: rdata_out <= {2'h0, lap_masks};
        ADDR_TICK_MASKS: rdata_out <= {1'b0, tick_masks};
        ADDR_SERIAL_FLAG: rdata_out <= {3'h0, serial_done_flag};
        ADDR_PORT_FLAGS: rdata_out <= {2'h0, aux_port_flag, key_port_flag};
        ADDR_LAP_FLAGS: rdata_out <= {2'h0, lap_flags};
        ADDR_TICK_FLAGS: rdata_out <= {1'b0, tick_flags};
        default: rdata_out <= DATA_ZERO;
      endcase
    end else begin
      rdata_out <= DATA_ZERO;
    end
  end

  // ****************************************************************
  // request logic
  // ****************************************************************
  assign tick_pend = |(tick_flags & tick_masks);
  assign lap_pend = |(lap_flags & lap_masks);
  assign input_pend = (key_port_flag && (|key_masks))
    || (AUX_INPUT_ONLY && aux_port_flag && aux_port_mask);
  assign serial_pend = serial_done_flag && serial_done_mask;
  assign any_pend = tick_pend || lap_pend || input_pend || serial_pend;
  assign irq_req_out = any_pend && global_irq_on;

  irq_vector_encoder vector_enc (
    .tick_pend_in(tick_pend),
    .lap_pend_in(lap_pend),
    .input_pend_in(input_pend),
    .serial_pend_in(serial_pend),
    .step_out(step)
  );

  always_comb begin
    case (state)
      ST_RUN: accept = irq_req_out && cpu_ctl_in.boundary;
      ST_HALT: accept = irq_req_out;
      ST_SLEEP: accept = input_pend && global_irq_on;
      ST_ENTRY: accept = 1'b0;
      default: accept = 1'b0;
    endcase
  end

  // ****************************************************************
  // global enable
  // ****************************************************************
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      global_irq_on <= 1'b0;
    end else if (accept) begin
      global_irq_on <= 1'b0;
    end else if (cpu_ctl_in.global_irq_off) begin
      global_irq_on <= 1'b0;
    end else if (cpu_ctl_in.global_irq_on) begin
      global_irq_on <= 1'b1;
    end
  end

  assign global_irq_flag_out = global_irq_on;

  // ****************************************************************
  // cpu sequencing
  // ****************************************************************
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state <= ST_RUN;
      entry_cnt <= CNT_ZERO;
    end else begin
      case (state)
        ST_RUN: begin
          if (accept) begin
            state <= ST_ENTRY;
            entry_cnt <= CNT_ZERO;
          end else if (cpu_ctl_in.halt_exec) begin
            state <= ST_HALT;
          end else if (sleep_go) begin
            state <= ST_SLEEP;
          end
        end
        ST_HALT, ST_SLEEP: begin
          if (accept) begin
            state <= ST_ENTRY;
            entry_cnt <= CNT_ZERO;
          end
        end
        ST_ENTRY: begin
          if (entry_cnt == ENTRY_LAST) begin
            state <= ST_RUN;
            entry_cnt <= CNT_ZERO;
          end else begin
            entry_cnt <= entry_cnt + CNT_ONE;
          end
        end
        default: begin
          state <= ST_RUN;
          entry_cnt <= CNT_ZERO;
        end
      endcase
    end
  end

  // ****************************************************************
  // return address and vector
  // ****************************************************************
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ret_addr <= '0;
    end else if (state == ST_RUN && (accept || cpu_ctl_in.halt_exec
                 || sleep_go)) begin
      ret_addr <= next_pc_in;
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      vector_out <= PC_WIDTH'({VECTOR_PAGE, STEP_RESET});
    end else if (accept) begin
      vector_out <= PC_WIDTH'({VECTOR_PAGE, step});
    end
  end

  assign push_addr_out = ret_addr;
  assign stack_push_out = entry_at(state, entry_cnt, CNT_ZERO);
  assign vector_load_out = entry_at(state, entry_cnt, ENTRY_LAST);
  assign cpu_hold_out = (state != ST_RUN);
  assign osc_run_out = (state != ST_SLEEP);
  assign lcd_power_out = (state != ST_SLEEP);

endmodule // irq_controller

// file: hw/irq_vector_encoder.sv
/*
 * combines pending flag groups into the page-1 vector step.
 * assumes flags and masks are already gated by the caller.
 */
module irq_vector_encoder (
  input wire logic tick_pend_in,
  input wire logic lap_pend_in,
  input wire logic input_pend_in,
  input wire logic serial_pend_in,
  output logic [7:0] step_out
);
  import irq_pkg::*;

  // ****************************************************************
  // group combine
  // ****************************************************************
  always_comb begin
    if (tick_pend_in || lap_pend_in || input_pend_in) begin
      step_out = {5'h00, input_pend_in, lap_pend_in, tick_pend_in};
    end else if (serial_pend_in) begin
      step_out = STEP_SERIAL;
    end else begin
      step_out = STEP_NONE;
    end
  end

endmodule // irq_vector_encoder
